/* File: verification/lpmc_wake_model.sv */
`timescale 1ns/1ps

module lpmc_wake_model (
  // command from the bench
  input  wire logic [4:0]  src,
  input  wire logic        on,
  input  wire logic [3:0]  clk_stop,
  // wake sources and clock state
  output logic      [17:0] ev,
  output logic      [3:0]  running
);
  // one source at a time, so each wake path is judged alone
  always_comb begin
    ev = '0;
    if (on) begin
      ev[src] = 1'b1;
    end
  end

  // a stopped clock is never reported running, so no switch may touch it
  assign running = ~clk_stop;
endmodule

/* File: verification/tb.sv */
`timescale 1ns/1ps
`include "lpmc_consts.svh"

module tb
  import lpmc_pkg::*;
;
  logic        mclk, rstn, enter_req, evt_timer_en, bod_reset_en, rst_pin_n, bod_trip, on;
  lpmc_mode_t  mode_sel;
  logic [15:0] periph_run_cfg, periph_keep_ds, periph_keep_pd, periph_clk_en;
  logic [4:0]  osc_en_cfg, osc_en_lp, osc_en, src;
  logic [5:0]  sram_ret_cfg, sram_retain;
  logic [17:0] ev;
  logic [3:0]  clk_stop, running;
  logic [1:0]  mux_req_sel, mux_sel;
  logic        cpu_clk_en, flash_pd, dcdc_off, core_pwr_off, evt_timer_pwr, cpu_state_retain;
  logic        pin_tristate, wake_pulse, sys_reset_req, rtc_wake_irq, bod_irq, bod_reset_req;
  logic        mux_gate, mux_busy, dma_clk_en;
  lpmc_state_t lp_state;
  int          bad_count, comparisons;

  lpmc_wake_model partner (.src(src), .on(on), .clk_stop(clk_stop), .ev(ev), .running(running));

  lpmc_top dut (
    .mclk(mclk), .rstn(rstn), .enter_req(enter_req), .mode_sel(mode_sel),
    .periph_run_cfg(periph_run_cfg), .periph_keep_ds(periph_keep_ds),
    .periph_keep_pd(periph_keep_pd), .osc_en_cfg(osc_en_cfg), .osc_en_lp(osc_en_lp),
    .sram_ret_cfg(sram_ret_cfg), .evt_timer_en(evt_timer_en), .bod_reset_en(bod_reset_en),
    .rst_pin_n(rst_pin_n), .wake_pin({ev[15], 2'h0, ev[14]}), .grp_int(ev[13:12]),
    .pin_int(ev[11]), .bod_trip(bod_trip), .irq_pending(ev[0]), .ctimer_evt(ev[1]),
    .utick_evt(ev[2]), .evt_timer_evt(ev[3]), .rtc_alarm(ev[4]),
    .one_hertz_alarm_flag(ev[5]), .wdt_evt(ev[6]), .usb_irq(ev[7]),
    .serial_irq({4'h0, ev[16], 2'h0, ev[17]}), .cmp_irq(ev[8]), .plu_irq(ev[9]),
    .dma_req(ev[10]), .mux_req_sel(mux_req_sel), .mux_src_running(running),
    .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_en(osc_en),
    .flash_pd(flash_pd), .dcdc_off(dcdc_off), .core_pwr_off(core_pwr_off),
    .evt_timer_pwr(evt_timer_pwr), .sram_retain(sram_retain),
    .cpu_state_retain(cpu_state_retain), .pin_tristate(pin_tristate), .dma_clk_en(dma_clk_en),
    .lp_state(lp_state), .wake_pulse(wake_pulse), .sys_reset_req(sys_reset_req),
    .rtc_wake_irq(rtc_wake_irq), .bod_irq(bod_irq), .bod_reset_req(bod_reset_req),
    .mux_sel(mux_sel), .mux_gate(mux_gate), .mux_busy(mux_busy)
  );

  always #4 mclk = ~mclk;

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic enter(input lpmc_mode_t m);
    @(negedge mclk);
    enter_req = 1'b1;
    mode_sel = m;
    @(negedge mclk);
    enter_req = 1'b0;
    @(negedge mclk);
    chk(lp_state, lpmc_state_t'(3'(m) + 3'h1));
    chk(cpu_clk_en, 1'b0);
  endtask

  task automatic wake(input lpmc_mode_t m, input int i);
    lpmc_state_t st;
    st = lp_state;
    src = 5'(i);
    on = 1'b1;
    // synchronised pins need two extra edges
    for (int n = 0; n < 6 && lp_state === st; n++) @(negedge mclk);
    chk(lp_state, (m == MODE_DPD) ? ST_RESTART : ST_ACTIVE);
    chk(wake_pulse, 1'b1);
    if (i == 5) chk(rtc_wake_irq, 1'b1);
    on = 1'b0;
    @(negedge mclk);
    if (m == MODE_DPD) begin
      chk(sys_reset_req, 1'b1);
      chk(lp_state, ST_ACTIVE);
    end else begin
      chk(cpu_clk_en, 1'b1);
      chk(dcdc_off, 1'b0);
    end
  endtask

  task automatic quiet(input int i);
    lpmc_state_t st;
    st = lp_state;
    src = 5'(i);
    on = 1'b1;
    repeat (5) @(negedge mclk);
    chk(lp_state, st);
    on = 1'b0;
    @(negedge mclk);
  endtask

  task automatic sweep(input lpmc_mode_t m, input logic [17:0] wm, input logic [17:0] qm);
    for (int i = 0; i < 18; i++) begin
      if (qm[i]) quiet(i);
    end
    for (int i = 0; i < 18; i++) begin
      if (wm[i]) begin
        if (lp_state === ST_ACTIVE) enter(m);
        wake(m, i);
      end
    end
  endtask

  task automatic t_sleep;
    enter(MODE_SLEEP);
    chk(periph_clk_en, periph_run_cfg);
    chk(flash_pd, 1'b0);
    sweep(MODE_SLEEP, 18'h01811, 18'h00400);
  endtask

  task automatic t_dsleep;
    enter(MODE_DSLEEP);
    chk(flash_pd, 1'b1);
    chk(periph_clk_en, periph_keep_ds);
    chk(osc_en, osc_en_lp);
    chk(sram_retain, sram_ret_cfg);
    // dma request clocks the dma path only, cpu stays off
    src = 5'h0A;
    on = 1'b1;
    repeat (2) @(negedge mclk);
    chk(dma_clk_en, 1'b1);
    chk(cpu_clk_en, 1'b0);
    chk(lp_state, ST_DSLEEP);
    on = 1'b0;
    @(negedge mclk);
    chk(dma_clk_en, 1'b0);
    // a generic pending interrupt is not a deep-sleep wake source
    sweep(MODE_DSLEEP, 18'h33BFE, 18'h00401);
    osc_en_lp = 5'h0C;
    enter(MODE_DSLEEP);
    chk(osc_en, 5'h0C);
    wake(MODE_DSLEEP, 2);
  endtask

  task automatic t_pdown;
    osc_en_lp = 5'h13;
    enter(MODE_PDOWN);
    chk(dcdc_off, 1'b1);
    chk(flash_pd, 1'b1);
    chk(periph_clk_en, periph_keep_pd & `LPMC_PD_KEEP_MASK);
    chk(osc_en, osc_en_lp & `LPMC_LP_OSC_MASK);
    chk(cpu_state_retain, 1'b1);
    chk(sram_retain, sram_ret_cfg);
    sweep(MODE_PDOWN, 18'h13138, 18'h20EC7);
  endtask

  task automatic t_dpd;
    evt_timer_en = 1'b0;
    enter(MODE_DPD);
    chk(pin_tristate, 1'b1);
    chk(core_pwr_off, 1'b1);
    chk(evt_timer_pwr, 1'b0);
    quiet(3);
    wake(MODE_DPD, 14);
    evt_timer_en = 1'b1;
    enter(MODE_DPD);
    chk(evt_timer_pwr, 1'b1);
    sweep(MODE_DPD, 18'h0C038, 18'h11101);
    // reset pin is synchronised, then the wake restarts
    enter(MODE_DPD);
    rst_pin_n = 1'b0;
    repeat (4) @(negedge mclk);
    chk(sys_reset_req, 1'b1);
    chk(lp_state, ST_ACTIVE);
    rst_pin_n = 1'b1;
    repeat (3) @(negedge mclk);
  endtask

  task automatic t_bod;
    int pulses;
    pulses = 0;
    bod_reset_en = 1'b1;
    bod_trip = 1'b1;
    repeat (8) begin
      @(negedge mclk);
      if (bod_reset_req === 1'b1) pulses++;
    end
    chk(pulses, 1);
    chk(bod_irq, 1'b0);
    bod_trip = 1'b0;
    repeat (4) @(negedge mclk);
    bod_reset_en = 1'b0;
    bod_trip = 1'b1;
    repeat (6) @(negedge mclk);
    chk(bod_irq, 1'b1);
    chk(bod_reset_req, 1'b0);
    bod_trip = 1'b0;
    repeat (6) @(negedge mclk);
    chk(bod_irq, 1'b0);
  endtask

  task automatic t_mux;
    int n;
    mux_req_sel = 2'h1;
    for (n = 0; n < 4 && mux_busy !== 1'b1; n++) @(negedge mclk);
    chk(mux_gate, 1'b0);
    chk(mux_sel, 2'h0);
    for (n = 0; n < 10 && mux_sel !== 2'h1; n++) @(negedge mclk);
    chk(n, 4);
    for (n = 0; n < 10 && mux_gate !== 1'b1; n++) @(negedge mclk);
    chk(n, 4);
    chk(mux_busy, 1'b0);
    // target clock stopped: the request must wait
    clk_stop = 4'h4;
    mux_req_sel = 2'h2;
    repeat (6) @(negedge mclk);
    chk(mux_busy, 1'b0);
    chk(mux_sel, 2'h1);
    clk_stop = 4'h0;
    repeat (12) @(negedge mclk);
    chk(mux_sel, 2'h2);
    chk(mux_gate, 1'b1);
  endtask

  initial begin
    mclk = 1'b0;
    rstn = 1'b0;
    enter_req = 1'b0;
    mode_sel = MODE_SLEEP;
    periph_run_cfg = 16'hA5A5;
    periph_keep_ds = 16'h3C0F;
    periph_keep_pd = 16'hFFFF;
    osc_en_cfg = 5'h15;
    osc_en_lp = 5'h1B;
    sram_ret_cfg = 6'h2D;
    evt_timer_en = 1'b1;
    bod_reset_en = 1'b0;
    rst_pin_n = 1'b1;
    bod_trip = 1'b0;
    src = 5'h00;
    on = 1'b0;
    clk_stop = 4'h0;
    mux_req_sel = 2'h0;
    bad_count = 0;
    comparisons = 0;
    repeat (4) @(negedge mclk);
    chk(lp_state, ST_ACTIVE);
    chk(cpu_clk_en, 1'b1);
    chk(osc_en, `LPMC_OSC_RESET);
    chk(periph_clk_en, 16'h0000);
    chk(evt_timer_pwr, 1'b1);
    chk(mux_gate, 1'b1);
    rstn = 1'b1;
    repeat (3) @(negedge mclk);
    chk(periph_clk_en, periph_run_cfg);
    chk(osc_en, osc_en_cfg);
    t_sleep;
    t_dsleep;
    t_pdown;
    t_dpd;
    t_bod;
    t_mux;
    test_done;
  end

  // generous bound: the whole sequence needs a few hundred cycles
  initial begin
    #200000;
    bad_count++;
    test_done;
  end
endmodule

/* File: verilog/lpmc_clk_switch.sv */
`timescale 1ns/1ps
`include "lpmc_consts.svh"

module lpmc_clk_switch
  import lpmc_pkg::*;
#(
  parameter int NSRC = 4
) (
  // clock and reset
  input  wire logic                    mclk,
  input  wire logic                    rstn,
  // request
  input  wire logic [$clog2(NSRC)-1:0] req_sel,
  input  wire logic [NSRC-1:0]         src_running,
  // mux control
  output logic      [$clog2(NSRC)-1:0] mux_sel,
  output logic                         mux_gate,
  output logic                         mux_busy
);

  lpmc_cs_t                    cs;
  logic [3:0]                  cnt;
  logic [$clog2(NSRC)-1:0]     tgt;

  // select only moves while the output is gated, so no runt pulse
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cs       <= CS_RUN;
      cnt      <= 4'h0;
      tgt      <= '0;
      mux_sel  <= '0;
      mux_gate <= 1'b1;
      mux_busy <= 1'b0;
    end else begin
      unique case (cs)
        CS_RUN: begin
          // both clocks must run, else the request waits
          if (req_sel != mux_sel && src_running[mux_sel] && src_running[req_sel]) begin
            cs       <= CS_OFF;
            tgt      <= req_sel;
            mux_gate <= 1'b0;
            mux_busy <= 1'b1;
            cnt      <= `LPMC_MUX_GAP;
          end
        end
        CS_OFF: begin
          if (cnt == 4'h0) begin
            mux_sel <= tgt;
            cs      <= CS_ON;
            cnt     <= `LPMC_MUX_GAP;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        CS_ON: begin
          if (cnt == 4'h0) begin
            mux_gate <= 1'b1;
            mux_busy <= 1'b0;
            cs       <= CS_RUN;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        default: cs <= CS_RUN;
      endcase
    end
  end

  property p_sel_gated;
    @(posedge mclk) disable iff (!rstn)
    $changed(mux_sel) |-> !mux_gate && $past(!mux_gate);
  endproperty
  a_sel_gated: assert property (p_sel_gated) else $error("mux select moved while open");

endmodule

/* File: verilog/lpmc_consts.svh */
`ifndef LPMC_CONSTS_SVH
`define LPMC_CONSTS_SVH

// peripheral clock slots
`define LPMC_NPERIPH     16
`define LPMC_PER_SERIAL3 3
`define LPMC_PER_RTC     8
`define LPMC_PER_EVTMR   9
`define LPMC_PER_CMP     10
// slots allowed to run in power-down: serial 3, rtc, event timer, comparator
`define LPMC_PD_KEEP_MASK 16'h0708

// clock source enables
`define LPMC_NOSC        5
`define LPMC_OSC_12M     0
`define LPMC_OSC_32K     1
`define LPMC_OSC_1M      2
`define LPMC_OSC_RTC32K  3
`define LPMC_OSC_EXT     4
// only the two 32 kHz sources may stay on in power-down and deep power-down
`define LPMC_LP_OSC_MASK 5'h0A
`define LPMC_OSC_RESET   5'h1F

`define LPMC_NSERIAL     8
`define LPMC_NSRAM       6

// synchroniser reset value: reset pin idles high, all others low
`define LPMC_SYNC_RESET  9'h100

// glitch-free mux settle count: each gap lasts this value plus one mclk cycles
`define LPMC_MUX_GAP     4'h3

`endif

/* File: verilog/lpmc_pkg.sv */
package lpmc_pkg;

  typedef enum logic [1:0] {
    MODE_SLEEP,
    MODE_DSLEEP,
    MODE_PDOWN,
    MODE_DPD
  } lpmc_mode_t;

  typedef enum logic [2:0] {
    ST_ACTIVE,
    ST_SLEEP,
    ST_DSLEEP,
    ST_PDOWN,
    ST_DPD,
    ST_RESTART
  } lpmc_state_t;

  typedef enum logic [1:0] {
    CS_RUN,
    CS_OFF,
    CS_ON
  } lpmc_cs_t;

endpackage

/* File: verilog/lpmc_top.sv */
`timescale 1ns/1ps
`include "lpmc_consts.svh"

module lpmc_top
  import lpmc_pkg::*;
#(
  parameter int NPERIPH = `LPMC_NPERIPH,
  parameter int NSERIAL = `LPMC_NSERIAL,
  parameter int NSRAM   = `LPMC_NSRAM,
  parameter int NMUXSRC = 4
) (
  // clock and reset
  input  wire logic                       mclk,
  input  wire logic                       rstn,
  // mode request from the cpu
  input  wire logic                       enter_req,
  input  wire lpmc_mode_t                 mode_sel,
  // software configuration
  input  wire logic [NPERIPH-1:0]         periph_run_cfg,
  input  wire logic [NPERIPH-1:0]         periph_keep_ds,
  input  wire logic [NPERIPH-1:0]         periph_keep_pd,
  input  wire logic [`LPMC_NOSC-1:0]      osc_en_cfg,
  input  wire logic [`LPMC_NOSC-1:0]      osc_en_lp,
  input  wire logic [NSRAM-1:0]           sram_ret_cfg,
  input  wire logic                       evt_timer_en,
  input  wire logic                       bod_reset_en,
  // pins and analog, asynchronous
  input  wire logic                       rst_pin_n,
  input  wire logic [3:0]                 wake_pin,
  input  wire logic [1:0]                 grp_int,
  input  wire logic                       pin_int,
  input  wire logic                       bod_trip,
  // on-chip wake sources and dma request, mclk domain
  input  wire logic                       irq_pending,
  input  wire logic                       ctimer_evt,
  input  wire logic                       utick_evt,
  input  wire logic                       evt_timer_evt,
  input  wire logic                       rtc_alarm,
  input  wire logic                       one_hertz_alarm_flag,
  input  wire logic                       wdt_evt,
  input  wire logic                       usb_irq,
  input  wire logic [NSERIAL-1:0]         serial_irq,
  input  wire logic                       cmp_irq,
  input  wire logic                       plu_irq,
  input  wire logic                       dma_req,
  // clock mux request
  input  wire logic [$clog2(NMUXSRC)-1:0] mux_req_sel,
  input  wire logic [NMUXSRC-1:0]         mux_src_running,
  // clock and power control
  output logic                            cpu_clk_en,
  output logic      [NPERIPH-1:0]         periph_clk_en,
  output logic      [`LPMC_NOSC-1:0]      osc_en,
  output logic                            flash_pd,
  output logic                            dcdc_off,
  output logic                            core_pwr_off,
  output logic                            evt_timer_pwr,
  output logic      [NSRAM-1:0]           sram_retain,
  output logic                            cpu_state_retain,
  output logic                            pin_tristate,
  output logic                            dma_clk_en,
  // events and status
  output lpmc_state_t                     lp_state,
  output logic                            wake_pulse,
  output logic                            sys_reset_req,
  output logic                            rtc_wake_irq,
  output logic                            bod_irq,
  output logic                            bod_reset_req,
  // clock mux
  output logic      [$clog2(NMUXSRC)-1:0] mux_sel,
  output logic                            mux_gate,
  output logic                            mux_busy
);

  localparam logic [NPERIPH-1:0] PD_KEEP = NPERIPH'(`LPMC_PD_KEEP_MASK);

  lpmc_state_t next_state;
  logic [8:0]  sync1;
  logic [8:0]  sync2;
  logic        rst_pin_s;
  logic [3:0]  wake_pin_s;
  logic [1:0]  grp_s;
  logic        pin_s;
  logic        bod_s;
  logic        bod_d;

  // pins and the brownout comparator are not on mclk
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      sync1 <= `LPMC_SYNC_RESET;
      sync2 <= `LPMC_SYNC_RESET;
    end else begin
      sync1 <= {rst_pin_n, wake_pin, grp_int, pin_int, bod_trip};
      sync2 <= sync1;
    end
  end

  assign rst_pin_s  = sync2[8];
  assign wake_pin_s = sync2[7:4];
  assign grp_s      = sync2[3:2];
  assign pin_s      = sync2[1];
  assign bod_s      = sync2[0];

  // which sources may end a given mode
  function automatic logic wake_hit(input lpmc_state_t s);
    logic rtc;
    rtc = rtc_alarm | one_hertz_alarm_flag;
    wake_hit = 1'b0;
    unique case (s)
      ST_SLEEP:
        wake_hit = !rst_pin_s | irq_pending | pin_s | (|grp_s) | rtc;
      ST_DSLEEP:
        wake_hit = !rst_pin_s | pin_s | (|grp_s) | ctimer_evt | utick_evt
                 | evt_timer_evt | rtc | wdt_evt | bod_s | usb_irq
                 | (|serial_irq) | cmp_irq | plu_irq;
      ST_PDOWN:
        wake_hit = !rst_pin_s | (|grp_s) | evt_timer_evt | rtc
                 | serial_irq[`LPMC_PER_SERIAL3] | cmp_irq;
      ST_DPD:
        wake_hit = !rst_pin_s | (|wake_pin_s) | rtc
                 | (evt_timer_evt & evt_timer_en);
      ST_ACTIVE,
      ST_RESTART:
        wake_hit = 1'b0;
    endcase
  endfunction

  always_comb begin
    next_state = lp_state;
    unique case (lp_state)
      ST_ACTIVE: begin
        if (enter_req) begin
          unique case (mode_sel)
            MODE_SLEEP:  next_state = ST_SLEEP;
            MODE_DSLEEP: next_state = ST_DSLEEP;
            MODE_PDOWN:  next_state = ST_PDOWN;
            MODE_DPD:    next_state = ST_DPD;
          endcase
        end
      end
      ST_SLEEP,
      ST_DSLEEP,
      ST_PDOWN: begin
        // state is retained, so execution simply resumes
        if (wake_hit(lp_state)) begin
          next_state = ST_ACTIVE;
        end
      end
      ST_DPD: begin
        if (wake_hit(lp_state)) begin
          next_state = ST_RESTART;
        end
      end
      ST_RESTART: next_state = ST_ACTIVE;
      // unused state codes fall back to active
      default:    next_state = ST_ACTIVE;
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      lp_state <= ST_ACTIVE;
    end else begin
      lp_state <= next_state;
    end
  end

  // wake and restart events
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      wake_pulse    <= 1'b0;
      sys_reset_req <= 1'b0;
    end else begin
      wake_pulse    <= wake_hit(lp_state);
      sys_reset_req <= (lp_state == ST_RESTART);
    end
  end

  // clocks: outputs follow the state one cycle later
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cpu_clk_en    <= 1'b1;
      periph_clk_en <= '0;
      osc_en        <= `LPMC_OSC_RESET;
      dma_clk_en    <= 1'b0;
    end else begin
      cpu_clk_en <= (lp_state == ST_ACTIVE) || (lp_state == ST_RESTART);
      // dma service in deep-sleep leaves the cpu asleep
      dma_clk_en <= (lp_state == ST_DSLEEP) && dma_req;
      unique case (lp_state)
        ST_ACTIVE,
        ST_RESTART,
        ST_SLEEP: begin
          periph_clk_en <= periph_run_cfg;
          osc_en        <= osc_en_cfg;
        end
        ST_DSLEEP: begin
          periph_clk_en <= periph_keep_ds;
          osc_en        <= osc_en_lp;
        end
        ST_PDOWN: begin
          periph_clk_en <= periph_keep_pd & PD_KEEP;
          osc_en        <= osc_en_lp & `LPMC_LP_OSC_MASK;
        end
        ST_DPD: begin
          periph_clk_en <= '0;
          osc_en        <= osc_en_lp & `LPMC_LP_OSC_MASK;
        end
      endcase
    end
  end

  // power domains, memories and pins
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      flash_pd         <= 1'b0;
      dcdc_off         <= 1'b0;
      core_pwr_off     <= 1'b0;
      evt_timer_pwr    <= 1'b1;
      sram_retain      <= '0;
      cpu_state_retain <= 1'b0;
      pin_tristate     <= 1'b0;
    end else begin
      flash_pd <= (lp_state == ST_DSLEEP) || (lp_state == ST_PDOWN)
               || (lp_state == ST_DPD);
      dcdc_off <= (lp_state == ST_PDOWN);
      core_pwr_off <= (lp_state == ST_DPD);
      // the event timer keeps power in deep power-down only when enabled
      evt_timer_pwr <= (lp_state != ST_DPD) || evt_timer_en;
      // banks not marked for retention stay fully active
      if (lp_state == ST_ACTIVE || lp_state == ST_SLEEP || lp_state == ST_RESTART) begin
        sram_retain <= '0;
      end else begin
        sram_retain <= sram_ret_cfg;
      end
      cpu_state_retain <= (lp_state == ST_PDOWN);
      pin_tristate     <= (lp_state == ST_DPD);
    end
  end

  // rtc and brownout
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rtc_wake_irq  <= 1'b0;
      bod_d         <= 1'b0;
      bod_irq       <= 1'b0;
      bod_reset_req <= 1'b0;
    end else begin
      rtc_wake_irq  <= one_hertz_alarm_flag;
      bod_d         <= bod_s;
      // interrupt is a level while low; reset is one pulse per trip
      bod_irq       <= bod_s && !bod_reset_en;
      bod_reset_req <= bod_s && !bod_d && bod_reset_en;
    end
  end

  lpmc_clk_switch #(
    .NSRC (NMUXSRC)
  ) u_clk_switch (
    .mclk        (mclk),
    .rstn        (rstn),
    .req_sel     (mux_req_sel),
    .src_running (mux_src_running),
    .mux_sel     (mux_sel),
    .mux_gate    (mux_gate),
    .mux_busy    (mux_busy)
  );

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);

  property p_sleep_cpu;
    lp_state == ST_SLEEP |=> !cpu_clk_en && periph_clk_en == $past(periph_run_cfg);
  endproperty
  a_sleep_cpu: assert property (p_sleep_cpu) else $error("cpu clock runs in sleep");

  property p_ds_gate;
    lp_state == ST_DSLEEP |=> flash_pd && !cpu_clk_en
                            && periph_clk_en == $past(periph_keep_ds);
  endproperty
  a_ds_gate: assert property (p_ds_gate) else $error("deep-sleep gating wrong");

  property p_ds_wake;
    lp_state == ST_DSLEEP && (utick_evt || plu_irq || wdt_evt) |=> lp_state == ST_ACTIVE;
  endproperty
  a_ds_wake: assert property (p_ds_wake) else $error("deep-sleep missed a wake");

  property p_ds_dma;
    lp_state == ST_DSLEEP && dma_req && !wake_hit(lp_state)
      |=> dma_clk_en && lp_state == ST_DSLEEP && !cpu_clk_en;
  endproperty
  a_ds_dma: assert property (p_ds_dma) else $error("dma service woke device");

  property p_ds_osc;
    lp_state == ST_DSLEEP |=> osc_en == $past(osc_en_lp);
  endproperty
  a_ds_osc: assert property (p_ds_osc) else $error("deep-sleep clock sources wrong");

  property p_pd_power;
    lp_state == ST_PDOWN |=> dcdc_off && flash_pd && cpu_state_retain
                           && (periph_clk_en & ~PD_KEEP) == '0;
  endproperty
  a_pd_power: assert property (p_pd_power) else $error("power-down control wrong");

  property p_pd_stay;
    lp_state == ST_PDOWN && rst_pin_s && grp_s == 2'b00 && !evt_timer_evt && !rtc_alarm
      && !one_hertz_alarm_flag && !serial_irq[`LPMC_PER_SERIAL3] && !cmp_irq
      |=> lp_state == ST_PDOWN;
  endproperty
  a_pd_stay: assert property (p_pd_stay) else $error("power-down left without cause");

  property p_dpd_off;
    lp_state == ST_DPD |=> core_pwr_off && pin_tristate && evt_timer_pwr == $past(evt_timer_en);
  endproperty
  a_dpd_off: assert property (p_dpd_off) else $error("deep power-down domains wrong");

  property p_dpd_restart;
    lp_state == ST_DPD && wake_pin_s != 4'h0
      |=> lp_state == ST_RESTART ##1 sys_reset_req && lp_state == ST_ACTIVE;
  endproperty
  a_dpd_restart: assert property (p_dpd_restart) else $error("no restart after wake");

  property p_alarm;
    $rose(one_hertz_alarm_flag) && lp_state != ST_ACTIVE && lp_state != ST_RESTART
      |=> rtc_wake_irq && wake_pulse;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm flag did not wake");

  property p_grp_wake;
    (lp_state == ST_SLEEP || lp_state == ST_DSLEEP || lp_state == ST_PDOWN) && grp_s != 2'b00
      |=> lp_state == ST_ACTIVE ##1 cpu_clk_en;
  endproperty
  a_grp_wake: assert property (p_grp_wake) else $error("group interrupt did not wake");

  property p_bod;
    $rose(bod_s) |=> (bod_reset_req == $past(bod_reset_en)) && (bod_irq != $past(bod_reset_en));
  endproperty
  a_bod: assert property (p_bod) else $error("brownout response wrong");

endmodule
